// ==== include/oob_flow_map.svh ====
// Purpose: constants for the out-of-band flow-control transmitter
// Assumes: one system clock acting as the link reference clock
// Notes:   widths, counts and the crc seed used by the serializer
`ifndef OOB_FLOW_MAP_SVH
`define OOB_FLOW_MAP_SVH

`define OOB_MAX_CAL      192
`define OOB_SLICE_BITS   64
`define OOB_SLICES       3
`define OOB_LANES        12
`define OOB_IDX_W        8
`define OOB_CRC_W        4
`define OOB_CRC_SEED     4'hF
`define OOB_CRC_POLY     4'h3
`define OOB_CRC_LAST     2'h3
`define OOB_BLK_LAST     6'h3F

`endif

// ==== include/oob_flow_pkg.sv ====
// Purpose: types shared by the flow-control transmitter
// Assumes: constants come from oob_flow_map.svh
// Notes:   link pins and health inputs travel as packed structs
`include "oob_flow_map.svh"

package oob_flow_pkg;

	// three link outputs that leave the device together
	typedef struct packed {
		logic clock;
		logic data;
		logic sync;
	} link_pins_t;

	// interface and per-lane health from user logic
	typedef struct packed {
		logic                   intf;
		logic [`OOB_LANES-1:0]  lanes;
	} health_t;

endpackage

// ==== src/oob_flow_transmitter.sv ====
// Purpose: serial transmitter of per-channel xon/xoff and health status
// Assumes: clk doubles as link reference clock; rst synchronous, active high
// Notes:   one bit per forwarded clock period, crc-4 after every 64 data bits
// Operation
// - with status enable high, send interface and lane health in the frame
// - with status enable low, ignore health inputs and send no status bits
// - strobe bit 0 captures channel bits 63..0 plus lane and interface health
// - strobe bit k captures the next 64-bit channel slice
// - data goes out serially, source synchronous with the forwarded clock
// - sync output marks the start of each frame for receiver alignment
// - channel bit one means xon, zero means xoff
// - reset holds every transmitter circuit in its reset state
`timescale 1ns/1ps
`include "oob_flow_map.svh"

module oob_flow_transmitter (
	input  wire logic                              clk,
	input  wire logic                              rst,
	input  wire logic [`OOB_MAX_CAL-1:0]           channel_flow_bits,
	input  wire logic [`OOB_IDX_W-1:0]             calendar_length_minus_one,
	input  wire logic [3:0]                        lane_count_minus_one,
	input  wire logic                              status_enable,
	input  wire oob_flow_pkg::health_t             health,
	output logic      [`OOB_SLICES-1:0]            update,
	output oob_flow_pkg::link_pins_t               link
);
	import oob_flow_pkg::*;

	logic [`OOB_MAX_CAL-1:0] fc_hold;
	health_t                 health_hold;
	logic                    status_frame;
	logic [`OOB_IDX_W-1:0]   idx;
	logic [5:0]              blk;
	logic                    crc_mode;
	logic [1:0]              crc_cnt;
	logic                    frame_done;
	logic [`OOB_CRC_W-1:0]   crc;
	logic [`OOB_IDX_W-1:0]   nstat;
	logic [`OOB_IDX_W-1:0]   total;
	logic [`OOB_IDX_W-1:0]   cal_pos;
	logic                    next_bit;
	logic                    emit;
	logic                    fwd_clock;
	logic                    ser_data;
	logic                    ser_sync;

	// one crc-4 step, polynomial x^4 + x + 1
	function automatic logic [`OOB_CRC_W-1:0] crc_step(input logic [`OOB_CRC_W-1:0] c, input logic d);
		logic fb;
		fb = c[3] ^ d;
		crc_step = {c[2:0], 1'b0} ^ (fb ? `OOB_CRC_POLY : 4'h0);
	endfunction

	// status bits lead the frame only when enabled: interface, then lanes
	assign nstat   = status_frame ? (`OOB_IDX_W'(lane_count_minus_one) + 8'h02) : 8'h00;
	assign total   = nstat + calendar_length_minus_one;                      // last data index
	assign cal_pos = idx - nstat;

	// each pin has a single driving process; the struct is only packed here
	assign link    = '{clock: fwd_clock, data: ser_data, sync: ser_sync};
	assign emit    = link.clock;                                              // falling edge of forwarded clock

	// bit chosen from the latched copies, never from live inputs
	always_comb begin
		if (idx < nstat) begin
			next_bit = (idx == 8'h00) ? health_hold.intf : health_hold.lanes[4'(idx - 8'h01)];
		end else begin
			next_bit = fc_hold[cal_pos];
		end
	end

	// forwarded clock: toggles every reference cycle, so half its rate
	always_ff @(posedge clk) begin
		if (rst) begin
			fwd_clock <= 1'b0;
		end else begin
			fwd_clock <= ~fwd_clock;
		end
	end

	// strobes decoded from state, high in the low half of the link clock before the slice
	// leaves; a registered strobe would capture on the same edge that shifts the bit out
	always_comb begin
		update = '0;
		if (!rst && !link.clock && !crc_mode) begin
			update[0] = (idx == 8'h00);
			update[1] = (idx >= nstat) && (cal_pos == 8'h40);
			update[2] = (idx >= nstat) && (cal_pos == 8'h80);
		end
	end

	// capture at the end of a strobed cycle; status zeroed when disabled
	always_ff @(posedge clk) begin
		if (rst) begin
			fc_hold      <= '0;
			health_hold  <= '0;
			status_frame <= 1'b0;
		end else begin
			if (update[0]) begin
				fc_hold[63:0] <= channel_flow_bits[63:0];
				status_frame  <= status_enable;
				health_hold   <= status_enable ? health : '0;
			end
			if (update[1]) begin
				fc_hold[127:64] <= channel_flow_bits[127:64];
			end
			if (update[2]) begin
				fc_hold[191:128] <= channel_flow_bits[191:128];
			end
		end
	end

	// serializer: data bits, crc after 64 bits or frame end, then repeat
	always_ff @(posedge clk) begin
		if (rst) begin
			idx        <= '0;
			blk        <= '0;
			crc_mode   <= 1'b0;
			crc_cnt    <= '0;
			frame_done <= 1'b0;
			crc        <= `OOB_CRC_SEED;
			ser_data   <= 1'b0;
			ser_sync   <= 1'b0;
		end else if (emit) begin
			if (crc_mode) begin
				ser_data  <= crc[2'(`OOB_CRC_LAST - crc_cnt)];
				ser_sync  <= 1'b0;
				crc_cnt   <= crc_cnt + 2'h1;
				if (crc_cnt == `OOB_CRC_LAST) begin
					crc_mode <= 1'b0;
					crc      <= `OOB_CRC_SEED;
					blk      <= '0;
					if (frame_done) begin
						idx        <= '0;
						frame_done <= 1'b0;
					end
				end
			end else begin
				ser_data  <= next_bit;
				ser_sync  <= (idx == 8'h00);
				crc       <= crc_step(crc, next_bit);
				blk       <= blk + 6'h01;
				idx       <= idx + 8'h01;
				if (idx == total || blk == `OOB_BLK_LAST) begin
					crc_mode   <= 1'b1;
					crc_cnt    <= '0;
					frame_done <= (idx == total);
				end
			end
		end
	end

	// framing check: sync lasts exactly one bit period
	sequence s_one_bit_mark;
		link.sync [*2] ##1 !link.sync;
	endsequence

	// strobe then framed bit two cycles later
	sequence s_frame_start;
		update[0] ##2 link.sync;
	endsequence

	property p_fwd_clock;
		@(posedge clk) disable iff (rst) !$past(rst) |-> link.clock != $past(link.clock);
	endproperty
	a_fwd_clock: assert property (p_fwd_clock) else $error("forwarded clock did not toggle");

	property p_one_strobe;
		@(posedge clk) disable iff (rst) $onehot0(update);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("more than one strobe");

	property p_frame_sync;
		@(posedge clk) disable iff (rst) update[0] |-> s_frame_start;
	endproperty
	a_frame_sync: assert property (p_frame_sync) else $error("sync missing after frame strobe");

	property p_sync_width;
		@(posedge clk) disable iff (rst) $rose(link.sync) |-> s_one_bit_mark;
	endproperty
	a_sync_width: assert property (p_sync_width) else $error("sync not one bit wide");

	property p_cap_slice0;
		@(posedge clk) disable iff (rst)
			update[0] |=> fc_hold[63:0] == $past(channel_flow_bits[63:0]);
	endproperty
	a_cap_slice0: assert property (p_cap_slice0) else $error("slice 0 not captured");

	property p_cap_slice1;
		@(posedge clk) disable iff (rst)
			update[1] |=> fc_hold[127:64] == $past(channel_flow_bits[127:64]);
	endproperty
	a_cap_slice1: assert property (p_cap_slice1) else $error("slice 1 not captured");

	property p_status_on;
		@(posedge clk) disable iff (rst)
			update[0] && status_enable |=> health_hold == $past(health) && status_frame;
	endproperty
	a_status_on: assert property (p_status_on) else $error("health not captured");

	property p_status_off;
		@(posedge clk) disable iff (rst)
			update[0] && !status_enable |=> health_hold == '0 && !status_frame;
	endproperty
	a_status_off: assert property (p_status_off) else $error("health not ignored");

	property p_data_edge;
		@(posedge clk) disable iff (rst) $changed(link.data) |-> !link.clock;
	endproperty
	a_data_edge: assert property (p_data_edge) else $error("data moved off falling edge");

	property p_crc_len;
		@(posedge clk) disable iff (rst) $rose(crc_mode) |-> crc_mode [*8];
	endproperty
	a_crc_len: assert property (p_crc_len) else $error("crc field shorter than four bits");

endmodule

// ==== tb/oob_flow_receiver_model.sv ====
// Purpose: listening peer that rebuilds frames from the link pins
// Assumes: clk oversamples the forwarded clock, two samples per bit
// Notes:   a frame is published when the next sync bit arrives
`timescale 1ns/1ps

module oob_flow_receiver_model (
	input wire logic                     clk,
	input wire logic                     rst,
	input wire oob_flow_pkg::link_pins_t link
);
	import oob_flow_pkg::*;

	logic [255:0]	cur;
	logic [255:0]	last;
	int		cnt;
	int		last_n;
	int		frames = 0;
	int		bad = 0;
	logic		prev_clock;
	logic		prev_rst;

	// sample on each rising forwarded clock; data was set up at the fall before
	always @(posedge clk) begin
		prev_clock <= link.clock;
		prev_rst <= rst;
		if (!rst && !prev_rst && link.clock === prev_clock) begin
			bad <= bad + 1;
		end
		if (rst) begin
			cnt <= 0;
		end else if (link.clock && !prev_clock) begin
			if (link.sync) begin
				last <= cur;
				last_n <= cnt;
				frames <= frames + 1;
				cur <= {255'h0, link.data};
				cnt <= 1;
			end else begin
				cur[cnt] <= link.data;
				cnt <= cnt + 1;
			end
		end
	end
endmodule

// ==== tb/oob_flow_transmitter_bench.sv ====
// Purpose: self-checking bench for the flow-control transmitter
// Assumes: 10 MHz clk, the receiver model rebuilds each frame
// Notes:   expected frames and crc are rebuilt here from the inputs
`timescale 1ns/1ps

module oob_flow_transmitter_bench;
	import oob_flow_pkg::*;

	logic		clk = 1'h0;
	logic		rst = 1'h1;
	logic [191:0]	ch = 192'h0;
	logic [7:0]	cal = 8'h0;
	logic [3:0]	lanes = 4'h0;
	logic		st = 1'h0;
	health_t	health = 13'h0;
	logic [2:0]	update;
	link_pins_t	link;
	logic [255:0]	exp_bits;
	int		exp_n;
	int		upd_seen [3];
	int		errors = 0;
	int		check_count = 0;
	int		cycles = 0;

	oob_flow_transmitter dut (.clk(clk), .rst(rst), .channel_flow_bits(ch), .calendar_length_minus_one(cal),
		.lane_count_minus_one(lanes), .status_enable(st), .health(health), .update(update), .link(link));
	oob_flow_receiver_model peer (.clk(clk), .rst(rst), .link(link));

	always #50 clk = ~clk;

	// watchdog, strobe counts and one-strobe-per-cycle check
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			final_report();
		end
		if (!rst && !$onehot0(update)) compare({253'h0, update}, 256'h0);
		for (int k = 0; k < 3; k++) upd_seen[k] += (update[k] === 1'h1);
	end

	task automatic compare(input logic [255:0] got, input logic [255:0] want);
		check_count++;
		if (got !== want) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	// settings only move while reset is held
	task automatic do_reset(input logic [7:0] c, input logic [3:0] l, input logic s);
		@(posedge clk);
		rst <= 1'h1;
		cal <= c;
		lanes <= l;
		st <= s;
		repeat (4) @(posedge clk);
		compare({update, link}, 256'h0);
		rst <= 1'h0;
		upd_seen = '{default: 0};
	endtask

	// frame = optional status, calendar, crc-4 after each 64 bits and at the end
	task automatic build(input logic s, input health_t h, input logic [191:0] c, input int nl, input int ncal);
		logic [255:0]	d;
		logic [3:0]	crc;
		int		n;
		d = 256'h0;
		crc = 4'hF;
		n = 0;
		exp_n = 0;
		exp_bits = 256'h0;
		if (s) begin
			d[0] = h.intf;
			for (int i = 0; i < nl; i++) d[1 + i] = h.lanes[i];
			n = 1 + nl;
		end
		for (int i = 0; i < ncal; i++) d[n + i] = c[i];
		n = n + ncal;
		for (int i = 0; i < n; i++) begin
			exp_bits[exp_n] = d[i];
			exp_n = exp_n + 1;
			crc = {crc[2:0], 1'h0} ^ ((crc[3] ^ d[i]) ? 4'h3 : 4'h0);
			if (i % 64 == 63 || i == n - 1) begin
				for (int k = 3; k >= 0; k--) begin
					exp_bits[exp_n] = crc[k];
					exp_n = exp_n + 1;
				end
				crc = 4'hF;
			end
		end
	endtask

	// returns on the edge that ends an update[0] cycle
	task automatic wait_strobe0();
		@(negedge clk);
		while (update[0] !== 1'h1) @(negedge clk);
		@(posedge clk);
	endtask

	task automatic wait_frames(input int n);
		int f0 = peer.frames;
		while (peer.frames < f0 + n) @(posedge clk);
	endtask

	// inputs moved at the capture edge must not leak into slice 0 or status
	task automatic test_status_on();
		health_t	h0 = 13'h1005;
		logic [191:0]	c1 = {122'h0, 6'h2A, 64'h0123_4567_89AB_CDEF};
		ch <= {122'h0, 6'h15, 64'h0123_4567_89AB_CDEF};
		health <= h0;
		do_reset(8'h45, 4'h2, 1'h1);
		wait_strobe0();
		ch <= {122'h0, 6'h2A, 64'hFFFF_0000_FFFF_0000};
		health <= 13'h0FFA;
		wait_frames(2);
		build(1'h1, h0, c1, 3, 70);
		compare(peer.last, exp_bits);
		compare(peer.last_n, exp_n);
		compare(upd_seen[1] > 0 && upd_seen[2] == 0, 1);
		compare(upd_seen[0], 2);
		compare(peer.bad, 0);
		$display("test_status_on done");
	endtask

	// full 192-entry calendar with twelve lanes, status held off
	task automatic test_status_off();
		logic [191:0]	c = {64'hC33C_5AA5_0FF0_9669, 64'h8001_7FFE_1248_EDB7, 64'hFEDC_BA98_7654_3210};
		ch <= c;
		health <= 13'h0A5A;
		do_reset(8'hBF, 4'hB, 1'h0);
		wait_strobe0();
		wait_frames(2);
		build(1'h0, 13'h0, c, 12, 192);
		compare(peer.last, exp_bits);
		compare(peer.last_n, exp_n);
		compare(upd_seen[2] > 0, 1);
		compare(upd_seen[0], 2);
		$display("test_status_off done");
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		test_status_on();
		test_status_off();
		final_report();
	end
endmodule
